// >>> rtl/cpt_pkg.sv
/*
 * constants shared by the pwm channel and its timebases: register offsets,
 * field positions, reset values and mode codes.
 * assumes an apb master with 32-bit data and byte addresses.
 */
// What this block does
// RULE1: period comes from selected timebase period register
// RULE2: period is (period+1)*4*prescale oscillator clocks
// RULE3: count equal period clears count next increment
// RULE4: rollover sets output unless duty is zero
// RULE5: rollover copies duty into shadow byte, latch
// RULE6: duty is byte plus control bits 5:4
// RULE7: duty writes anytime, effective after next rollover
// RULE8: shadow byte read-only while in pwm mode
// RULE9: duty double-buffered in shadow plus 2-bit latch
// RULE10: extended count matching duty clears output
// RULE11: duty beyond period keeps output high
// RULE12: timer3 select bits choose timer2 or timer4
// RULE13: software sets up in the recommended order
// RULE14: prescaler divides by 1, 4 or 16
// RULE15: software clears direction bit for output drive
// RULE16: zero channel control forces output low
package cpt_pkg;
    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int REG_W = 8;
    localparam int ADDR_W = 12;
    localparam int DUTY_W = REG_W + 2;
    localparam int PRE_W = 4;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFS_T2_COUNT = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_T2_PERIOD = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_T2_CTRL = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_T3_CTRL = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_T4_COUNT = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_T4_PERIOD = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_T4_CTRL = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_DUTY = 12'h01c;
    localparam logic [ADDR_W-1:0] OFS_SHADOW = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_CH_CTRL = 12'h024;
    localparam logic [ADDR_W-1:0] OFS_PORT_DIR = 12'h028;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [REG_W-1:0] RST_COUNT = 8'h00;
    localparam logic [REG_W-1:0] RST_PERIOD = 8'hff;
    localparam logic [REG_W-1:0] RST_CTRL = 8'h00;
    localparam logic [REG_W-1:0] RST_DUTY = 8'h00;
    localparam logic RST_PORT_DIR = 1'b1;

    // ****************************************************************
    // field positions and masks
    // ****************************************************************
    localparam logic [REG_W-1:0] TCTRL_MASK = 8'h7f;   // timer2 and timer4 control bit 7 unimplemented
    localparam int TCTRL_RUN = 2;
    localparam int T3_SEL_HI = 6;
    localparam int T3_SEL_LO = 3;
    localparam logic [REG_W-1:0] CCTRL_MASK = 8'h3f;   // channel control bits 7:6 unimplemented
    localparam int CCTRL_DLO_HI = 5;
    localparam int CCTRL_DLO_LO = 4;
    localparam int CCTRL_MODE_HI = 3;
    localparam int CCTRL_MODE_PWM_LO = 2;
    localparam logic [1:0] MODE_PWM = 2'h3;

    // ****************************************************************
    // prescale and quarter-cycle codes
    // ****************************************************************
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV4 = 2'h1;
    localparam logic [PRE_W-1:0] PRE_LIM1 = 4'h0;
    localparam logic [PRE_W-1:0] PRE_LIM4 = 4'h3;
    localparam logic [PRE_W-1:0] PRE_LIM16 = 4'hf;
    localparam logic [1:0] Q_LAST = 2'h3;              // oscillator clocks per instruction cycle minus one
    localparam logic [1:0] T3_SEL_T2 = 2'h0;
endpackage

// >>> rtl/cpt_tb_if.sv
/*
 * timebase carrier between the controller, the timers and the pwm stage.
 * assumes one clock domain for all parties.
 */
`timescale 1ns/1ps
interface cpt_tb_if #(parameter int W = 8);
    logic [W-1:0] period;   // period register
    logic run;              // timer enabled
    logic [1:0] prescale;   // prescale select
    logic wr_count;         // software count write
    logic [W-1:0] wdata;    // count write data
    logic [W-1:0] count;    // timer count
    logic [1:0] low2;       // two extension bits of count
    logic step;             // extended count advances
    logic rollover;         // count cleared at period match
    modport timer(input period, run, prescale, wr_count, wdata, output count, low2, step, rollover);
    modport ctrl(output period, run, prescale, wr_count, wdata, input count, low2, step, rollover);
    modport pwm(input count, low2, step, rollover);
endinterface

// >>> rtl/cpt_timebase.sv
/*
 * 8-bit timebase with 1/4/16 prescaler and quarter-cycle phase.
 * assumes the controller drives period, run, prescale and count writes.
 */
`timescale 1ns/1ps
module cpt_timebase #(
    parameter int W = 8
) (
    input wire logic clk_i,      // system clock
    input wire logic rst_n_i,    // sync reset, low
    cpt_tb_if.timer tb           // timebase carrier
);
    import cpt_pkg::*;

    logic [1:0] q_phase_q;
    logic [PRE_W-1:0] pre_q;
    logic [W-1:0] cnt_q;
    logic [PRE_W-1:0] pre_lim;
    logic inc_cyc;
    logic tick;

    // ****************************************************************
    // prescaler
    // ****************************************************************
    // prescale limit per select code
    always_comb begin
        case (tb.prescale)
            PS_DIV1: pre_lim = PRE_LIM1;
            PS_DIV4: pre_lim = PRE_LIM4;
            default: pre_lim = PRE_LIM16;
        endcase
    end

    assign inc_cyc = (q_phase_q == Q_LAST);
    assign tick = tb.run && inc_cyc && (pre_q == pre_lim); // RULE14

    // free-running quarter-cycle phase
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q_phase_q <= 2'h0;
        end else begin
            q_phase_q <= q_phase_q + 2'h1;
        end
    end

    // instruction-cycle prescaler, held clear while stopped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !tb.run) begin
            pre_q <= '0;
        end else if (inc_cyc) begin
            pre_q <= (pre_q == pre_lim) ? '0 : pre_q + 4'h1; // RULE14
        end
    end

    // ****************************************************************
    // counter
    // ****************************************************************
    // count wraps to zero on the increment after a period match
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= RST_COUNT;
        end else if (tb.wr_count) begin
            cnt_q <= tb.wdata;
        end else if (tick) begin
            cnt_q <= (cnt_q == tb.period) ? '0 : cnt_q + 8'h01; // RULE3
        end
    end

    // extension bits and advance strobe of the 10-bit count
    always_comb begin
        case (tb.prescale)
            PS_DIV1: begin
                tb.low2 = q_phase_q; // RULE10
                tb.step = tb.run;
            end
            PS_DIV4: begin
                tb.low2 = pre_q[1:0];
                tb.step = tb.run && inc_cyc;
            end
            default: begin
                tb.low2 = pre_q[3:2];
                tb.step = tb.run && inc_cyc && (pre_q[1:0] == PRE_LIM4[1:0]);
            end
        endcase
    end

    assign tb.count = cnt_q;
    assign tb.rollover = tick && (cnt_q == tb.period) && !tb.wr_count; // RULE2 RULE3
endmodule

// >>> rtl/cpt_pwm_stage.sv
/*
 * double-buffered duty and pwm output latch.
 * assumes a selected timebase on the carrier and mode decode from the controller.
 */
`timescale 1ns/1ps
module cpt_pwm_stage (
    input wire logic clk_i,                         // system clock
    input wire logic rst_n_i,                       // sync reset, low
    cpt_tb_if.pwm tb,                               // selected timebase
    input wire logic pwm_en_i,                      // pwm mode active
    input wire logic [cpt_pkg::REG_W-1:0] duty_i,   // writable duty byte
    input wire logic [1:0] duty_low_i,              // two low duty bits
    input wire logic shadow_wr_i,                   // shadow write outside pwm
    input wire logic [cpt_pkg::REG_W-1:0] shadow_wdata_i, // shadow write data
    output logic [cpt_pkg::REG_W-1:0] shadow_o,     // shadow duty byte
    output logic out_o                              // pwm output latch
);
    import cpt_pkg::*;

    logic [REG_W-1:0] shadow_q;
    logic [1:0] latch_q;
    logic out_q;
    logic [DUTY_W-1:0] next_duty;
    logic [DUTY_W-1:0] ext_next;

    assign next_duty = {duty_i, duty_low_i}; // RULE6
    assign ext_next = {tb.count, tb.low2} + 10'h001;

    // ****************************************************************
    // duty buffer
    // ****************************************************************
    // duty loaded only at rollover; shadow writable only outside pwm
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            shadow_q <= RST_DUTY;
            latch_q <= 2'h0;
        end else if (pwm_en_i && tb.rollover) begin
            shadow_q <= duty_i; // RULE5 RULE7 RULE9
            latch_q <= duty_low_i; // RULE5 RULE9
        end else if (shadow_wr_i && !pwm_en_i) begin
            shadow_q <= shadow_wdata_i; // RULE8
        end
    end

    // ****************************************************************
    // output latch
    // ****************************************************************
    // set at rollover, cleared when extended count reaches duty
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !pwm_en_i) begin
            out_q <= 1'b0; // RULE16
        end else if (tb.rollover) begin
            out_q <= (next_duty != '0); // RULE4
        end else if (tb.step && (ext_next == {shadow_q, latch_q})) begin
            out_q <= 1'b0; // RULE10 RULE11
        end
    end

    assign shadow_o = shadow_q;
    assign out_o = out_q;
endmodule

// >>> rtl/cpt_pwm_channel.sv
/*
 * pwm channel top: apb register file, two timebases, timebase select
 * and the pwm output stage.
 * assumes an apb master on the system clock and an external pin pad
 * that combines PWM_O with PWM_OE_N_O.
 */
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module cpt_pwm_channel (
    input wire logic CLK_SYS_I, // 200 mhz system clock
    input wire logic RST_N_I, // sync reset, low
    input wire logic PSEL_I, // apb select
    input wire logic PENABLE_I, // apb enable
    input wire logic PWRITE_I, // apb direction
    input wire logic [cpt_pkg::ADDR_W-1:0] PADDR_I, // apb byte address
    input wire logic [31:0] PWDATA_I, // apb write data
    input wire logic [3:0] PSTRB_I, // apb byte strobes
    output logic [31:0] PRDATA_O, // apb read data
    output logic PREADY_O, // apb ready
    output logic PSLVERR_O, // apb error
    output logic PWM_O, // pwm output pin value
    output logic PWM_OE_N_O // pin output enable, low drives
);
    import cpt_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    cpt_tb_if #(.W(REG_W)) tb2_if();
    cpt_tb_if #(.W(REG_W)) tb4_if();
    cpt_tb_if #(.W(REG_W)) sel_if();

    logic [REG_W-1:0] t2_period_q;
    logic [REG_W-1:0] t2_ctrl_q;
    logic [REG_W-1:0] t3_ctrl_q;
    logic [REG_W-1:0] t4_period_q;
    logic [REG_W-1:0] t4_ctrl_q;
    logic [REG_W-1:0] duty_q;
    logic [REG_W-1:0] ch_ctrl_q;
    logic port_dir_q;
    logic [31:0] prdata_q;
    logic [REG_W-1:0] shadow;
    logic pwm_out;
    logic setup;
    logic wr_en;
    logic mapped;
    logic [REG_W-1:0] wbyte;
    logic [REG_W-1:0] rd_byte;
    logic use_t4;
    logic pwm_en;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    // setup phase samples read data; access phase completes at once
    assign setup = PSEL_I && !PENABLE_I;
    assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && mapped && PSTRB_I[0];
    assign wbyte = PWDATA_I[REG_W-1:0];

    // address map and read mux
    always_comb begin
        mapped = 1'b1;
        case (PADDR_I)
            OFS_T2_COUNT: rd_byte = tb2_if.count;
            OFS_T2_PERIOD: rd_byte = t2_period_q;
            OFS_T2_CTRL: rd_byte = t2_ctrl_q;
            OFS_T3_CTRL: rd_byte = t3_ctrl_q;
            OFS_T4_COUNT: rd_byte = tb4_if.count;
            OFS_T4_PERIOD: rd_byte = t4_period_q;
            OFS_T4_CTRL: rd_byte = t4_ctrl_q;
            OFS_DUTY: rd_byte = duty_q;
            OFS_SHADOW: rd_byte = shadow;
            OFS_CH_CTRL: rd_byte = ch_ctrl_q;
            OFS_PORT_DIR: rd_byte = {{(REG_W-1){1'b0}}, port_dir_q};
            default: begin
                rd_byte = '0;
                mapped = 1'b0;
            end
        endcase
    end

    // read data captured in setup, held through access
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !PWRITE_I) begin
            prdata_q <= {{(32-REG_W){1'b0}}, rd_byte};
        end
    end

    assign PRDATA_O = prdata_q;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

    // ****************************************************************
    // timer2 registers
    // ****************************************************************
    // period and control of timer2
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            t2_period_q <= RST_PERIOD;
            t2_ctrl_q <= RST_CTRL;
        end else if (wr_en) begin
            if (PADDR_I == OFS_T2_PERIOD) begin
                t2_period_q <= wbyte; // RULE1
            end
            if (PADDR_I == OFS_T2_CTRL) begin
                t2_ctrl_q <= wbyte & TCTRL_MASK;
            end
        end
    end

    // ****************************************************************
    // timer3 control
    // ****************************************************************
    // only the timebase select bits act here
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            t3_ctrl_q <= RST_CTRL;
        end else if (wr_en && PADDR_I == OFS_T3_CTRL) begin
            t3_ctrl_q <= wbyte;
        end
    end

    // ****************************************************************
    // timer4 registers
    // ****************************************************************
    // period and control of timer4
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            t4_period_q <= RST_PERIOD;
            t4_ctrl_q <= RST_CTRL;
        end else if (wr_en) begin
            if (PADDR_I == OFS_T4_PERIOD) begin
                t4_period_q <= wbyte; // RULE1
            end
            if (PADDR_I == OFS_T4_CTRL) begin
                t4_ctrl_q <= wbyte & TCTRL_MASK;
            end
        end
    end

    // ****************************************************************
    // channel registers
    // ****************************************************************
    // duty byte and channel control, writable at any time
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            duty_q <= RST_DUTY;
            ch_ctrl_q <= RST_CTRL;
        end else if (wr_en) begin
            if (PADDR_I == OFS_DUTY) begin
                duty_q <= wbyte; // RULE7
            end
            if (PADDR_I == OFS_CH_CTRL) begin
                ch_ctrl_q <= wbyte & CCTRL_MASK; // RULE7
            end
        end
    end

    // pin direction bit, reset to input
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            port_dir_q <= RST_PORT_DIR;
        end else if (wr_en && PADDR_I == OFS_PORT_DIR) begin
            port_dir_q <= wbyte[0];
        end
    end

    // ****************************************************************
    // timebases
    // ****************************************************************
    // controller side of timer2
    assign tb2_if.period = t2_period_q;
    assign tb2_if.run = t2_ctrl_q[TCTRL_RUN];
    assign tb2_if.prescale = t2_ctrl_q[1:0];
    assign tb2_if.wr_count = wr_en && (PADDR_I == OFS_T2_COUNT);
    assign tb2_if.wdata = wbyte;

    // controller side of timer4
    assign tb4_if.period = t4_period_q;
    assign tb4_if.run = t4_ctrl_q[TCTRL_RUN];
    assign tb4_if.prescale = t4_ctrl_q[1:0];
    assign tb4_if.wr_count = wr_en && (PADDR_I == OFS_T4_COUNT);
    assign tb4_if.wdata = wbyte;

    cpt_timebase #(.W(REG_W)) u_timer2 (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .tb(tb2_if.timer)
    );

    cpt_timebase #(.W(REG_W)) u_timer4 (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .tb(tb4_if.timer)
    );

    // ****************************************************************
    // timebase select
    // ****************************************************************
    // select code zero picks timer2, any other code timer4
    assign use_t4 = ({t3_ctrl_q[T3_SEL_HI], t3_ctrl_q[T3_SEL_LO]} != T3_SEL_T2); // RULE12
    assign sel_if.count = use_t4 ? tb4_if.count : tb2_if.count; // RULE12
    assign sel_if.low2 = use_t4 ? tb4_if.low2 : tb2_if.low2;
    assign sel_if.step = use_t4 ? tb4_if.step : tb2_if.step;
    assign sel_if.rollover = use_t4 ? tb4_if.rollover : tb2_if.rollover; // RULE1

    // unused controller fields of the selected carrier
    assign sel_if.period = '0;
    assign sel_if.run = 1'b0;
    assign sel_if.prescale = 2'h0;
    assign sel_if.wr_count = 1'b0;
    assign sel_if.wdata = '0;

    // ****************************************************************
    // pwm stage
    // ****************************************************************
    // pwm mode is mode bits 3:2 both set; zero control clears the latch
    assign pwm_en = (ch_ctrl_q[CCTRL_MODE_HI:CCTRL_MODE_PWM_LO] == MODE_PWM); // RULE16

    cpt_pwm_stage u_pwm (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .tb(sel_if.pwm),
        .pwm_en_i(pwm_en),
        .duty_i(duty_q),
        .duty_low_i(ch_ctrl_q[CCTRL_DLO_HI:CCTRL_DLO_LO]),
        .shadow_wr_i(wr_en && (PADDR_I == OFS_SHADOW)),
        .shadow_wdata_i(wbyte),
        .shadow_o(shadow),
        .out_o(pwm_out)
    );

    // pin value and enable; direction bit low drives the pin
    assign PWM_O = pwm_out;
    assign PWM_OE_N_O = port_dir_q; // RULE15
endmodule

// >>> test/cpt_pwm_channel_checker.sv
/*
 * concurrent checks on the pwm channel top ports.
 * assumes one clock domain and a sync active-low reset.
 */
`timescale 1ns/1ps
module cpt_pwm_channel_checker
    import cpt_pkg::*;
(
    input wire logic CLK_SYS_I, // system clock
    input wire logic RST_N_I, // sync reset, low
    input wire logic PSEL_I, // apb select
    input wire logic PENABLE_I, // apb enable
    input wire logic PWRITE_I, // apb direction
    input wire logic [ADDR_W-1:0] PADDR_I, // apb address
    input wire logic [31:0] PWDATA_I, // apb write data
    input wire logic [3:0] PSTRB_I, // apb strobes
    input wire logic [31:0] PRDATA_O, // apb read data
    input wire logic PREADY_O, // apb ready
    input wire logic PSLVERR_O, // apb error
    input wire logic PWM_O, // pwm output
    input wire logic PWM_OE_N_O // pin enable, low drives
);
    // ****************************************************************
    // helper decode of writes
    // ****************************************************************
    logic acc;
    logic wr_ch;
    logic wr_dir;
    logic pwm_mode_q;
    assign acc = PSEL_I && PENABLE_I;
    assign wr_ch = acc && PWRITE_I && PSTRB_I[0] && PADDR_I == OFS_CH_CTRL;
    assign wr_dir = acc && PWRITE_I && PSTRB_I[0] && PADDR_I == OFS_PORT_DIR;
    // tracks whether pwm mode is programmed
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            pwm_mode_q <= 1'b0;
        end else if (wr_ch) begin
            pwm_mode_q <= PWDATA_I[3:2] == MODE_PWM;
        end
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    property p_ready; acc |-> PREADY_O; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access");
    property p_err_phase; PSLVERR_O |-> acc; endproperty
    a_err_phase: assert property (p_err_phase) else $error("error outside access");
    property p_err_map; acc && PADDR_I > OFS_PORT_DIR |-> PSLVERR_O && (PWRITE_I || PRDATA_O == 32'h0); endproperty
    a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
    property p_reset; disable iff (1'b0) !RST_N_I |=> !PWM_O && PWM_OE_N_O && PRDATA_O == 32'h0; endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");
    property p_dir; wr_dir |=> PWM_OE_N_O == $past(PWDATA_I[0]); endproperty
    a_dir: assert property (p_dir) else $error("direction bit not applied");
    property p_clear; wr_ch && PWDATA_I[7:0] == 8'h00 |-> ##2 !PWM_O [*3]; endproperty
    a_clear: assert property (p_clear) else $error("output not forced low");
    property p_off; !pwm_mode_q && !$past(pwm_mode_q) |-> !PWM_O; endproperty
    a_off: assert property (p_off) else $error("output high outside pwm mode");
    property p_rise; $rose(PWM_O) |-> $past(pwm_mode_q); endproperty
    a_rise: assert property (p_rise) else $error("output set outside pwm mode");
endmodule
bind cpt_pwm_channel cpt_pwm_channel_checker u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PWM_O(PWM_O), .PWM_OE_N_O(PWM_OE_N_O));

// >>> test/cpt_pwm_load.sv
/*
 * load on the pwm pin: level and pulse widths.
 * assumes a pull-down while the pin is not driven.
 */
`timescale 1ns/1ps
module cpt_pwm_load (
    input wire logic clk_i, // system clock
    input wire logic rst_n_i, // sync reset, low
    input wire logic pwm_i, // channel output value
    input wire logic oe_n_i, // channel drive enable, low
    output logic pin_o, // pin level
    output logic [15:0] period_o, // last rise-to-rise cycles
    output logic [15:0] high_o // last high cycles
);
    logic last_q;
    logic [15:0] per_q;
    logic [15:0] hi_q;
    // pull-down wins when undriven
    assign pin_o = oe_n_i ? 1'b0 : pwm_i;
    // measure pulse width and period on the pin
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            last_q <= 1'b0;
            per_q <= 16'h0;
            hi_q <= 16'h0;
            period_o <= 16'h0;
            high_o <= 16'h0;
        end else begin
            last_q <= pin_o;
            per_q <= (pin_o && !last_q) ? 16'h1 : per_q + 16'h1;
            hi_q <= (pin_o && !last_q) ? 16'h1 : hi_q + {15'h0, pin_o};
            if (pin_o && !last_q) period_o <= per_q;
            if (!pin_o && last_q) high_o <= hi_q;
        end
    end
endmodule

// >>> test/cpt_pwm_channel_tb_top.sv
/*
 * self-checking bench: apb tasks, register reset checks and pwm waveforms.
 * assumes the checker is bound by its own file.
 */
`timescale 1ns/1ps
module cpt_pwm_channel_tb_top;
    import cpt_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic pwm;
    logic oe_n;
    logic pin;
    logic [15:0] m_per;
    logic [15:0] m_high;
    logic [7:0] rst_tab [11] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    int failures = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    cpt_pwm_channel uut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .PWM_O(pwm), .PWM_OE_N_O(oe_n));
    cpt_pwm_load u_load (.clk_i(clk), .rst_n_i(rst_n), .pwm_i(pwm), .oe_n_i(oe_n), .pin_o(pin),
        .period_o(m_per), .high_o(m_high));
    // ****************************************************************
    // tasks
    // ****************************************************************
    task print_verdict;
        $display("compares %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, read data left in rd
    task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            failures++;
            print_verdict();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_pin(input logic v);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pin !== v && n < 300);
        if (n >= 300) begin
            failures++;
            print_verdict();
        end
    endtask
    // program in the recommended order, then count high cycles over two periods
    task run_case(input logic sel, input logic [1:0] ps, input logic [7:0] per, input logic [9:0] duty);
        int psf;
        int cyc;
        int hi;
        int cnt;
        logic [ADDR_W-1:0] b;
        psf = (ps == PS_DIV1) ? 1 : (ps == PS_DIV4) ? 4 : 16;
        cyc = (per + 1) * 4 * psf;
        hi = (duty * psf < cyc) ? duty * psf : cyc;
        b = sel ? 12'h010 : 12'h000;
        apb(1'b1, OFS_CH_CTRL, 32'h0);
        apb(1'b1, OFS_T2_CTRL, 32'h0);
        apb(1'b1, OFS_T4_CTRL, 32'h0);
        apb(1'b1, OFS_T3_CTRL, sel ? 32'h40 : 32'h0);
        apb(1'b1, OFS_T2_PERIOD + b, {24'h0, per});
        apb(1'b1, OFS_T2_COUNT + b, 32'h0);
        apb(1'b1, OFS_DUTY, {24'h0, duty[9:2]});
        apb(1'b1, OFS_PORT_DIR, 32'h0);
        apb(1'b1, OFS_T2_CTRL + b, {29'h0, 1'b1, ps});
        apb(1'b1, OFS_CH_CTRL, {26'h0, duty[1:0], 4'hc});
        repeat (2 * cyc) @(posedge clk);
        cnt = 0;
        repeat (2 * cyc) begin
            @(posedge clk);
            if (pin === 1'b1) cnt++;
        end
        check(cnt, 2 * hi);
        if (duty != 0 && hi < cyc) check(m_per, cyc);
        if (duty != 0 && hi < cyc) check(m_high, hi);
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            apb(1'b0, ADDR_W'(i * 4), 32'h0);
            check(rd, {24'h0, rst_tab[i]});
        end
        apb(1'b0, 12'h02c, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, OFS_T2_CTRL, 32'hff);
        apb(1'b0, OFS_T2_CTRL, 32'h0);
        check(rd, {24'h0, TCTRL_MASK});
        run_case(1'b1, 2'h1, 8'h02, 10'h5);
        run_case(1'b0, 2'h2, 8'h01, 10'h3);
        run_case(1'b1, 2'h3, 8'h00, 10'h2);
        run_case(1'b0, 2'h0, 8'h02, 10'h0);
        run_case(1'b0, 2'h0, 8'h01, 10'h3ff);
        run_case(1'b0, 2'h0, 8'h03, 10'h6);
        wait_pin(1'b1);
        apb(1'b1, OFS_DUTY, 32'h2);
        wait_pin(1'b0);
        @(posedge clk);
        check(m_high, 32'h6);
        repeat (40) @(posedge clk);
        check(m_high, 32'ha);
        apb(1'b0, OFS_SHADOW, 32'h0);
        check(rd, 32'h2);
        apb(1'b1, OFS_SHADOW, 32'h55);
        apb(1'b0, OFS_SHADOW, 32'h0);
        check(rd, 32'h2);
        wait_pin(1'b1);
        apb(1'b1, OFS_CH_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        check(pwm, 1'b0);
        print_verdict();
    end
endmodule
